// [rtl/tmps_top.sv]
// destination resolution: trunk reduction plus mirror copies
module tmps_top
  import tmps_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  input wire logic clk,
  input wire logic rst,
  // lookup request
  input wire logic req_valid,
  input wire logic req_multicast,
  input wire logic [PORT_W-1:0] req_src_port,
  input wire logic [MAC_W-1:0] req_sa,
  input wire logic [MAC_W-1:0] req_da,
  input wire logic [PORT_W-1:0] req_dst_port,
  input wire logic req_dst_trunked,
  input wire logic [TRUNK_W-1:0] req_dst_trunk,
  input wire logic [PORTS-1:0] req_vlan_members,
  input wire logic req_sa_mirror,
  input wire logic req_da_mirror,
  // configuration
  input wire logic [1:0] cfg_hash_mode,
  input wire logic cfg_ring_mode,
  input wire logic [NUM_TRUNKS*PORTS-1:0] cfg_trunk_members,
  input wire logic [NUM_TRUNKS*NUM_SEL*PORT_W-1:0] cfg_member_sel,
  input wire logic cfg_flow_en,
  input wire logic cfg_flow_rev_en,
  input wire logic [MAC_W-1:0] cfg_flow_sa,
  input wire logic [MAC_W-1:0] cfg_flow_da,
  input wire logic [NUM_MON-1:0] cfg_mon_en,
  input wire logic [NUM_MON*PORT_W-1:0] cfg_mon_port,
  input wire logic [NUM_MON*PORT_W-1:0] cfg_mon_src,
  input wire logic [NUM_MON-1:0] cfg_mon_egress,
  input wire logic [NUM_MON-1:0] cfg_mon_addr,
  // result
  output logic res_valid,
  output logic [PORTS-1:0] res_dest,
  output logic [PORTS-1:0] res_mirror,
  output logic res_discard
);
  // every port number has to fit the port-number field
  if (PORTS < 2 || PORTS > (1 << PORT_W)) begin : g_bad_ports
    $error("unsupported port count");
  end

  tmps_state_t state_q;
  logic [1:0] mode_eff;
  logic [SEL_W-1:0] hidx;
  logic [PORTS-1:0] dest_d;
  logic [PORTS-1:0] mir_d;
  logic disc_d;
  logic [PORTS-1:0] mon_mask;
  logic [PORTS-1:0] trunked_all;
  logic [PORTS-1:0] addr_mon_mask;
  logic [PORTS-1:0] dtrunk_set;

  logic mc_q;
  logic [PORT_W-1:0] src_q;
  logic [MAC_W-1:0] sa_q;
  logic [MAC_W-1:0] da_q;
  logic [PORT_W-1:0] dst_q;
  logic dtr_q;
  logic [TRUNK_W-1:0] dtrunk_q;
  logic [PORTS-1:0] vlan_q;
  logic sam_q;
  logic dam_q;

  function automatic logic [PORTS-1:0] trunk_set(input int t);
    return cfg_trunk_members[t*PORTS +: PORTS];
  endfunction

  function automatic logic [PORT_W-1:0] member(input int t, input logic [SEL_W-1:0] i);
    return cfg_member_sel[(t*NUM_SEL + int'(i))*PORT_W +: PORT_W];
  endfunction

  function automatic logic [PORTS-1:0] onehot(input logic [PORT_W-1:0] p);
    logic [PORTS-1:0] r;
    r = '0;
    if (int'(p) < PORTS) begin
      r[p] = 1'b1;
    end
    return r;
  endfunction

  // no trunk holds more than one port of the set
  function automatic logic trunks_single(input logic [PORTS-1:0] s);
    logic ok;
    ok = 1'b1;
    for (int t = 0; t < NUM_TRUNKS; t++) begin
      if ($countones(s & trunk_set(t)) > 1) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // source-port hashing only in ring mode
  assign mode_eff = (cfg_hash_mode == HASH_SRC_PORT && !cfg_ring_mode) ? HASH_SA_DA
                                                                      : cfg_hash_mode;

  tmps_hash u_hash (
    .mode(mode_eff),
    .sa(sa_q),
    .da(da_q),
    .src_port(src_q),
    .idx(hidx)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= TMPS_IDLE;
    end else begin
      case (state_q)
        TMPS_IDLE: if (req_valid) state_q <= TMPS_RESOLVE;
        TMPS_RESOLVE: state_q <= TMPS_OUT;
        TMPS_OUT: state_q <= TMPS_IDLE;
        default: state_q <= TMPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mc_q <= 1'b0;
      src_q <= '0;
      sa_q <= '0;
      da_q <= '0;
      dst_q <= '0;
      dtr_q <= 1'b0;
      dtrunk_q <= '0;
      vlan_q <= '0;
      sam_q <= 1'b0;
      dam_q <= 1'b0;
    end else if (state_q == TMPS_IDLE && req_valid) begin
      mc_q <= req_multicast;
      src_q <= req_src_port;
      sa_q <= req_sa;
      da_q <= req_da;
      dst_q <= req_dst_port;
      dtr_q <= req_dst_trunked;
      dtrunk_q <= req_dst_trunk;
      vlan_q <= req_vlan_members;
      sam_q <= req_sa_mirror;
      dam_q <= req_da_mirror;
    end
  end

  always_comb begin
    mon_mask = '0;
    for (int m = 0; m < NUM_MON; m++) begin
      if (cfg_mon_en[m]) begin
        mon_mask = mon_mask | onehot(cfg_mon_port[m*PORT_W +: PORT_W]);
      end
    end
  end

  always_comb begin
    trunked_all = '0;
    for (int t = 0; t < NUM_TRUNKS; t++) begin
      trunked_all = trunked_all | trunk_set(t);
    end
  end

  // monitors that take address and flow hits
  always_comb begin
    addr_mon_mask = '0;
    for (int m = 0; m < NUM_MON; m++) begin
      if (cfg_mon_en[m] && cfg_mon_addr[m]) begin
        addr_mon_mask = addr_mon_mask | onehot(cfg_mon_port[m*PORT_W +: PORT_W]);
      end
    end
  end

  // process form so the trunk mask follows configuration changes too
  always_comb begin
    dtrunk_set = trunk_set(int'(dtrunk_q));
  end

  // forwarding set, independent of any mirror decision
  always_comb begin
    logic [PORTS-1:0] cand;
    logic [PORTS-1:0] srcoh;
    cand = '0;
    srcoh = onehot(src_q);
    disc_d = 1'b0;
    if (mc_q) begin
      cand = vlan_q;
      if ((trunked_all & srcoh) == '0) begin
        cand = cand & ~srcoh;
      end
      for (int t = 0; t < NUM_TRUNKS; t++) begin
        if ((trunk_set(t) & srcoh) != '0) begin
          cand = cand & ~trunk_set(t);
        end else if ((cand & trunk_set(t)) != '0) begin
          cand = (cand & ~trunk_set(t)) | (cand & onehot(member(t, hidx)));
        end
      end
    end else if (dtr_q) begin
      if ((trunk_set(int'(dtrunk_q)) & srcoh) != '0) begin
        disc_d = 1'b1;
      end else begin
        cand = onehot(member(int'(dtrunk_q), hidx));
      end
    end else begin
      cand = onehot(dst_q);
    end
    dest_d = cand & ~mon_mask;
  end

  // mirror copies, a separate vector alongside the forwarding set
  always_comb begin
    logic hit;
    mir_d = '0;
    hit = 1'b0;
    if (cfg_flow_en && sa_q == cfg_flow_sa && da_q == cfg_flow_da) begin
      hit = 1'b1;
    end
    if (cfg_flow_en && cfg_flow_rev_en && sa_q == cfg_flow_da && da_q == cfg_flow_sa) begin
      hit = 1'b1;
    end
    if (sam_q || dam_q) begin
      hit = 1'b1;
    end
    for (int m = 0; m < NUM_MON; m++) begin
      if (cfg_mon_en[m]) begin
        if (cfg_mon_addr[m]) begin
          if (hit) mir_d = mir_d | onehot(cfg_mon_port[m*PORT_W +: PORT_W]);
        end else if (cfg_mon_egress[m]) begin
          if ((dest_d & onehot(cfg_mon_src[m*PORT_W +: PORT_W])) != '0) begin
            mir_d = mir_d | onehot(cfg_mon_port[m*PORT_W +: PORT_W]);
          end
        end else if (src_q == cfg_mon_src[m*PORT_W +: PORT_W]) begin
          mir_d = mir_d | onehot(cfg_mon_port[m*PORT_W +: PORT_W]);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_dest <= '0;
      res_mirror <= '0;
      res_discard <= 1'b0;
    end else begin
      res_valid <= (state_q == TMPS_RESOLVE);
      if (state_q == TMPS_RESOLVE) begin
        res_dest <= dest_d;
        res_mirror <= mir_d;
        res_discard <= disc_d;
      end
    end
  end

  property p_latency;
    @(posedge clk) disable iff (rst) (state_q == TMPS_IDLE && req_valid) |-> ##2 res_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result late");

  property p_discard_empty;
    @(posedge clk) disable iff (rst) res_valid && res_discard |-> res_dest == '0;
  endproperty
  a_discard_empty: assert property (p_discard_empty) else $error("discard with dest");

  property p_mon_excluded;
    @(posedge clk) disable iff (rst) res_valid |-> (res_dest & $past(mon_mask)) == '0;
  endproperty
  a_mon_excluded: assert property (p_mon_excluded) else $error("monitor forwarded");

  property p_mc_src_out;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && mc_q |=> (res_dest & onehot($past(src_q))) == '0;
  endproperty
  a_mc_src_out: assert property (p_mc_src_out) else $error("ingress echoed");

  property p_mc_one_per_trunk;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && mc_q |-> trunks_single(dest_d);
  endproperty
  a_mc_one_per_trunk: assert property (p_mc_one_per_trunk) else $error("two members");

  property p_mc_in_vlan;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && mc_q |=> (res_dest & ~$past(vlan_q)) == '0;
  endproperty
  a_mc_in_vlan: assert property (p_mc_in_vlan) else $error("outside vlan");

  property p_uc_single;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && !mc_q |=> $countones(res_dest) <= 1;
  endproperty
  a_uc_single: assert property (p_uc_single) else $error("unicast fanout");

  property p_uc_drop;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && !mc_q && dtr_q && (dtrunk_set & onehot(src_q)) != '0
      |=> res_discard;
  endproperty
  a_uc_drop: assert property (p_uc_drop) else $error("trunk echo kept");

  property p_uc_trunk_member;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && !mc_q && dtr_q |=> (res_dest & ~$past(dtrunk_set)) == '0;
  endproperty
  a_uc_trunk_member: assert property (p_uc_trunk_member) else $error("left the trunk");

  property p_ring_only;
    @(posedge clk) disable iff (rst)
      cfg_hash_mode == HASH_SRC_PORT && !cfg_ring_mode |-> mode_eff == HASH_SA_DA;
  endproperty
  a_ring_only: assert property (p_ring_only) else $error("port hash outside ring");

  property p_mirror_only_mon;
    @(posedge clk) disable iff (rst) res_valid |-> (res_mirror & ~$past(mon_mask)) == '0;
  endproperty
  a_mirror_only_mon: assert property (p_mirror_only_mon) else $error("copy off monitor");

  property p_addr_mirror;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && (sam_q || dam_q)
      |=> (res_mirror & $past(addr_mon_mask)) == $past(addr_mon_mask);
  endproperty
  a_addr_mirror: assert property (p_addr_mirror) else $error("address not mirrored");

  property p_rev_flow;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && cfg_flow_en && cfg_flow_rev_en
      && sa_q == cfg_flow_da && da_q == cfg_flow_sa
      |=> (res_mirror & $past(addr_mon_mask)) == $past(addr_mon_mask);
  endproperty
  a_rev_flow: assert property (p_rev_flow) else $error("reverse flow not mirrored");

  property p_flow_mirror;
    @(posedge clk) disable iff (rst)
      state_q == TMPS_RESOLVE && cfg_flow_en && sa_q == cfg_flow_sa && da_q == cfg_flow_da
      |=> (res_mirror & $past(addr_mon_mask)) == $past(addr_mon_mask);
  endproperty
  a_flow_mirror: assert property (p_flow_mirror) else $error("flow not mirrored");

  c_mc: cover property (@(posedge clk) disable iff (rst) res_valid && $past(mc_q, 2));
  c_disc: cover property (@(posedge clk) disable iff (rst) res_valid && res_discard);
  c_mir: cover property (@(posedge clk) disable iff (rst) res_valid && res_mirror != '0);
  c_uc_trunk: cover property (@(posedge clk) disable iff (rst)
    state_q == TMPS_RESOLVE && dtr_q && !mc_q && !disc_d);
  c_two_mon: cover property (@(posedge clk) disable iff (rst)
    res_valid && $countones(res_mirror) == 2);
endmodule

// [rtl/tmps_pkg.sv]
// Operation
// - eight trunk groups, each with up to eight member ports
// - unicast member chosen by hash: sa+da default, sa, da, source port
// - multicast uses the same selectable hash options as unicast
// - trunk-flagged destination entry yields its trunk group number
// - unicast dropped when ingress port is in the destination trunk
// - each trunk has eight member-select entries indexed by the hash
// - hash is a pure function of key fields, so flows stay ordered
// - multicast candidates start from the vlan member set
// - multicast drops the ingress trunk, or the ingress port alone
// - multicast keeps one hash-chosen port per remaining trunk
// - software reprograms member entries when a member link fails
// - address mirror: flagged entry, source or destination selector
// - flow mirror: sa and da equal the programmed pair
// - reverse flow mirror: sa and da equal programmed da and sa
// - port mirror copies a port's ingress or egress to a monitor
// - at most two monitor ports at once
// - monitor ports are removed from normal forwarding
package tmps_pkg;
  localparam int NUM_PORTS = 10;
  localparam int NUM_TRUNKS = 8;
  localparam int NUM_SEL = 8;
  localparam int PORT_W = 4;
  localparam int TRUNK_W = 3;
  localparam int SEL_W = 3;
  localparam int MAC_W = 48;
  localparam int NUM_MON = 2;
  localparam int LATENCY = 2;
  localparam logic [1:0] HASH_SA_DA = 2'h0;
  localparam logic [1:0] HASH_SA = 2'h1;
  localparam logic [1:0] HASH_DA = 2'h2;
  localparam logic [1:0] HASH_SRC_PORT = 2'h3;
  typedef enum logic [1:0] {
    TMPS_IDLE,
    TMPS_RESOLVE,
    TMPS_OUT
  } tmps_state_t;
endpackage

// [rtl/tmps_hash.sv]
// folds the selected key fields into a member-select index
module tmps_hash
  import tmps_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic [MAC_W-1:0] sa,
  input wire logic [MAC_W-1:0] da,
  input wire logic [PORT_W-1:0] src_port,
  output logic [SEL_W-1:0] idx
);
  function automatic logic [SEL_W-1:0] fold(input logic [MAC_W-1:0] v);
    logic [SEL_W-1:0] r;
    r = '0;
    for (int i = 0; i < MAC_W; i += SEL_W) begin
      r = r ^ v[i +: SEL_W];
    end
    return r;
  endfunction

  always_comb begin
    case (mode)
      HASH_SA: idx = fold(sa);
      HASH_DA: idx = fold(da);
      HASH_SRC_PORT: idx = src_port[SEL_W-1:0];
      default: idx = fold(sa) ^ fold(da);
    endcase
  end
endmodule

// [testbench/tmps_qm_model.sv]
// egress queue manager side: takes each result on its valid edge
module tmps_qm_model
  import tmps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic res_valid,
  input wire logic [NUM_PORTS-1:0] res_dest,
  input wire logic [NUM_PORTS-1:0] res_mirror,
  input wire logic res_discard,
  output logic [NUM_PORTS-1:0] got_dest,
  output logic [NUM_PORTS-1:0] got_mirror,
  output logic got_discard,
  output int got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got_dest <= '0;
      got_mirror <= '0;
      got_discard <= 1'b0;
      got_cnt <= 0;
    end else if (res_valid) begin
      got_dest <= res_dest;
      got_mirror <= res_mirror;
      got_discard <= res_discard;
      got_cnt <= got_cnt + 1;
    end
  end
endmodule

// [testbench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tmps_pkg::*;
  logic clk, rst, rv, mc, tr, sm, dm, ring, fen, fren, valid, disc, gdisc;
  logic [PORT_W-1:0] sp, dp;
  logic [TRUNK_W-1:0] dt;
  logic [MAC_W-1:0] sa, da, fsa, fda;
  logic [9:0] vl, dest, mir, gd, gm;
  logic [1:0] hm, men, meg, mad;
  logic [79:0] tm;
  logic [255:0] ms;
  logic [7:0] mp, msrc;
  int n_errors, compares, gcnt, n_req;

  tmps_top dut_u (.clk(clk), .rst(rst), .req_valid(rv), .req_multicast(mc),
    .req_src_port(sp), .req_sa(sa), .req_da(da),
    .req_dst_port(dp), .req_dst_trunked(tr), .req_dst_trunk(dt), .req_vlan_members(vl),
    .req_sa_mirror(sm), .req_da_mirror(dm), .cfg_hash_mode(hm), .cfg_ring_mode(ring),
    .cfg_trunk_members(tm), .cfg_member_sel(ms), .cfg_flow_en(fen),
    .cfg_flow_rev_en(fren), .cfg_flow_sa(fsa), .cfg_flow_da(fda), .cfg_mon_en(men),
    .cfg_mon_port(mp), .cfg_mon_src(msrc), .cfg_mon_egress(meg), .cfg_mon_addr(mad),
    .res_valid(valid), .res_dest(dest), .res_mirror(mir), .res_discard(disc));
  tmps_qm_model qm_u (.clk(clk), .rst(rst), .res_valid(valid), .res_dest(dest),
    .res_mirror(mir), .res_discard(disc), .got_dest(gd), .got_mirror(gm),
    .got_discard(gdisc), .got_cnt(gcnt));

  always #4 clk = ~clk;

  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_ports(input string what, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_cnt(input string what, input int e, input int g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %0d seen %0d", what, e, g);
    end
  endtask
  function automatic logic [2:0] fold(input logic [47:0] x);
    fold = 3'h0;
    for (int i = 0; i < 16; i++) fold ^= x[i*3+:3];
  endfunction
  // member port picked for trunk t under the current key
  function automatic logic [9:0] pick(input int t);
    logic [2:0] i;
    i = (hm == 2'h1) ? fold(sa) : (hm == 2'h2) ? fold(da) :
        (hm == 2'h3 && ring) ? sp[2:0] : fold(sa ^ da);
    pick = 10'h001 << ms[(t*8+i)*4+:4];
  endfunction
  task automatic go;
    @(negedge clk) rv = 1'b1;
    @(negedge clk) rv = 1'b0;
    chk_bit("res_valid early", 1'b0, valid);
    @(negedge clk) chk_bit("res_valid", 1'b1, valid);
    @(negedge clk) chk_bit("res_valid pulse", 1'b0, valid);
    n_req++;
    chk_cnt("results taken", n_req, gcnt);
  endtask

  task automatic t_uc;
    mc = 0; tr = 1; dt = 0; sp = 5;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        hm = 2'(m); ring = k[0]; sa = 48'h0123_4567_89ab + k; da = 48'hfedc_ba98_7654 - 3 * k;
        go;
        chk_ports("uc dest", pick(0), gd);
        chk_bit("uc discard", 1'b0, gdisc);
        go;
        chk_ports("uc repeat", pick(0), gd);
      end
    end
    sp = 1;
    go;
    chk_bit("uc drop", 1'b1, gdisc);
    chk_ports("uc drop dest", 10'h000, gd);
  endtask
  task automatic t_mc;
    mc = 1; vl = 10'h07f;
    for (int m = 0; m < 3; m++) begin
      hm = 2'(m); sa = 48'h1357_9bdf_0246 * (m + 1);
      sp = 3;
      go;
      chk_ports("mc trunk src", pick(0) | 10'h060, gd);
      sp = 5;
      go;
      chk_ports("mc port src", pick(0) | pick(1) | 10'h040, gd);
    end
  endtask
  task automatic t_fail;
    for (int i = 0; i < 8; i++) ms[i*4+:4] = 4'(1 + i % 2);
    mc = 0; hm = 0; sp = 5;
    for (int k = 0; k < 6; k++) begin
      sa = 48'h0a0b_0c0d_0e0f + 7 * k;
      go;
      chk_ports("failover dest", pick(0), gd);
      chk_bit("failover dead member", 1'b0, gd[0]);
    end
  endtask
  task automatic t_port_mir;
    men = 2'h3; mp = 8'h89; msrc = 8'h65; meg = 2'h2; tr = 0; sp = 5; dp = 6;
    go;
    chk_ports("port mir dest", 10'h040, gd);
    chk_ports("port mir", 10'h300, gm);
    dp = 9;
    go;
    chk_ports("mon dest", 10'h000, gd);
    chk_ports("mon mir", 10'h200, gm);
    mc = 1; vl = 10'h3e0;
    go;
    chk_ports("mc mon dest", 10'h0c0, gd);
    chk_ports("mc mon mir", 10'h300, gm);
  endtask
  task automatic t_addr_mir;
    mc = 0; men = 2'h2; mad = 2'h2; sp = 7; dp = 5; sm = 1;
    go;
    chk_ports("sa mir", 10'h100, gm);
    chk_ports("addr dest", 10'h020, gd);
    sm = 0; dm = 1;
    go;
    chk_ports("da mir", 10'h100, gm);
    dm = 0; fen = 1; sa = fsa; da = fda;
    go;
    chk_ports("flow mir", 10'h100, gm);
    sa = fda; da = fsa;
    go;
    chk_ports("rev off", 10'h000, gm);
    fren = 1;
    go;
    chk_ports("rev on", 10'h100, gm);
  endtask

  initial begin
    clk = 0; rst = 1; rv = 0; mc = 0; tr = 0; sm = 0; dm = 0; ring = 0; fen = 0; fren = 0;
    sp = 0; dp = 0; dt = 0; sa = 0; da = 0; vl = 0; hm = 0; men = 0; meg = 0; mad = 0;
    mp = 0; msrc = 0; n_errors = 0; compares = 0; n_req = 0;
    fsa = 48'h0200_1122_3344; fda = 48'h0200_5566_7788;
    tm = {60'h0, 10'h018, 10'h007};
    for (int i = 0; i < 8; i++) begin
      ms[i*4+:4] = 4'(i % 3);
      ms[(8+i)*4+:4] = 4'(3 + i % 2);
    end
    ms[255:64] = '0;
    repeat (16) @(negedge clk);
    rst = 0;
    t_uc;
    t_mc;
    t_fail;
    t_port_mir;
    t_addr_mir;
    report_and_stop;
  end
  initial begin
    // about ten times the expected length of the run
    #20000;
    n_errors++;
    report_and_stop;
  end
endmodule
